// ==== rtl/master_command_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module master_command_status_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] dip_switch,
  input wire logic setup_mode,
  input wire logic run_lamp,
  input wire logic link_refreshing,
  input wire logic stations_gathered,
  output logic link_halt,
  output logic eep_wr_busy,
  output logic [5:0] eep_wr_addr,
  output logic [15:0] eep_wr_data,
  output logic eep_wr_strobe,
  input wire logic eep_wr_ack,
  output logic irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [12:0] pins_s;
  mcs_sync #(.WIDTH(13)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({eep_wr_ack, stations_gathered, link_refreshing, run_lamp, setup_mode, dip_switch}),
    .q(pins_s)
  );
  logic ack_s, gathered_s, refresh_s, run_s, setup_s;
  logic [7:0] dip_s;
  assign ack_s = pins_s[12];
  assign gathered_s = pins_s[11];
  assign refresh_s = pins_s[10];
  assign run_s = pins_s[9];
  assign setup_s = pins_s[8];
  assign dip_s = pins_s[7:0];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [7:0] idx;
  logic idx_ok, wr_acc, rd_setup;
  assign idx = paddr[9:2];
  assign idx_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  logic is_sw, is_cmd, is_st, is_is, is_im, is_info;
  assign is_sw = idx_ok && (idx == mcs_pkg::SWITCH_IDX);
  assign is_cmd = idx_ok && (idx == mcs_pkg::COMMAND_IDX);
  assign is_st = idx_ok && (idx == mcs_pkg::STATUS_IDX);
  assign is_is = idx_ok && (idx == mcs_pkg::IRQ_STATUS_IDX);
  assign is_im = idx_ok && (idx == mcs_pkg::IRQ_MASK_IDX);
  assign is_info = idx_ok && (idx >= mcs_pkg::INFO_BASE_IDX) && (idx <= mcs_pkg::INFO_LAST_IDX);

  logic mapped;
  assign mapped = is_sw || is_cmd || is_st || is_is || is_im || is_info;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // switch capture
  // ----------------------------------------
  // caught once after reset release, as at power-on; waits for the synchroniser to fill
  logic [7:0] switch_q;
  logic sw_cap_q;
  logic [1:0] sw_wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_q <= mcs_pkg::SWITCH_RESET;
      sw_cap_q <= 1'b0;
      sw_wait_q <= 2'h0;
    end else if (!sw_cap_q) begin
      if (sw_wait_q == 2'(mcs_pkg::SWITCH_SETTLE)) begin
        switch_q <= dip_s;
        sw_cap_q <= 1'b1;
      end else begin
        sw_wait_q <= sw_wait_q + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // command word and edge detection
  // ----------------------------------------
  logic [15:0] cmd_q;
  logic wr_req_prev_q, stop_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= mcs_pkg::CMD_RESET;
    end else if (wr_acc && is_cmd) begin
      cmd_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_req_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
    end else begin
      wr_req_prev_q <= cmd_q[mcs_pkg::CMD_EEP_WR_BIT];
      stop_prev_q <= cmd_q[mcs_pkg::CMD_STOP_BIT];
    end
  end

  logic wr_req_rise, stop_rise, stop_fall;
  assign wr_req_rise = cmd_q[mcs_pkg::CMD_EEP_WR_BIT] && !wr_req_prev_q;
  assign stop_rise = cmd_q[mcs_pkg::CMD_STOP_BIT] && !stop_prev_q;
  assign stop_fall = !cmd_q[mcs_pkg::CMD_STOP_BIT] && stop_prev_q;

  // ----------------------------------------
  // data link halt
  // ----------------------------------------
  logic halt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (stop_rise) begin
      halt_q <= 1'b1;
    end else if (stop_fall) begin
      halt_q <= 1'b0;
    end
  end
  assign link_halt = halt_q;

  // ----------------------------------------
  // eeprom copy sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {EEP_IDLE, EEP_READ, EEP_WRITE, EEP_DONE} eep_state_e;
  eep_state_e eep_q;
  logic [5:0] copy_idx_q;
  logic wdone_q;
  logic refused_ev;
  assign refused_ev = wr_req_rise && !setup_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eep_q <= EEP_IDLE;
      copy_idx_q <= 6'h00;
    end else begin
      unique case (eep_q)
        EEP_IDLE: begin
          if (wr_req_rise && setup_s) begin
            eep_q <= EEP_READ;
            copy_idx_q <= 6'h00;
          end
        end
        EEP_READ: eep_q <= EEP_WRITE;
        EEP_WRITE: begin
          if (ack_s) begin
            if (copy_idx_q == 6'h3f) begin
              eep_q <= EEP_DONE;
            end else begin
              copy_idx_q <= copy_idx_q + 6'h01;
              eep_q <= EEP_READ;
            end
          end
        end
        EEP_DONE: begin
          if (!cmd_q[mcs_pkg::CMD_EEP_WR_BIT]) begin
            eep_q <= EEP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdone_q <= 1'b0;
    end else if (eep_q == EEP_WRITE && ack_s && copy_idx_q == 6'h3f) begin
      wdone_q <= 1'b1;
    end else if (eep_q == EEP_DONE && !cmd_q[mcs_pkg::CMD_EEP_WR_BIT]) begin
      wdone_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // station information memory
  // ----------------------------------------
  // one read port shared; copy has priority, bus reads of info may see copy data
  // copy addresses run one word ahead so the registered read is ready in EEP_READ
  logic [15:0] mem_rd;
  logic [5:0] mem_rd_addr;
  always_comb begin
    mem_rd_addr = 6'(idx - mcs_pkg::INFO_BASE_IDX);
    if (eep_q == EEP_WRITE) begin
      mem_rd_addr = copy_idx_q + 6'h01;
    end else if (eep_q == EEP_READ) begin
      mem_rd_addr = copy_idx_q;
    end else if (eep_q == EEP_IDLE && wr_req_rise && setup_s) begin
      mem_rd_addr = 6'h00;
    end
  end
  mcs_info_mem u_mem (
    .pclk(pclk),
    .wr_en(wr_acc && is_info),
    .wr_addr(6'(idx - mcs_pkg::INFO_BASE_IDX)),
    .wr_data(pwdata[15:0]),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eep_wr_data <= 16'h0000;
      eep_wr_addr <= 6'h00;
    end else if (eep_q == EEP_READ) begin
      eep_wr_data <= mem_rd;
      eep_wr_addr <= copy_idx_q;
    end
  end
  assign eep_wr_strobe = (eep_q == EEP_WRITE);
  assign eep_wr_busy = (eep_q != EEP_IDLE);

  // ----------------------------------------
  // status word
  // ----------------------------------------
  logic [15:0] status_w;
  always_comb begin
    status_w = 16'h0000;
    status_w[mcs_pkg::ST_LINK_BIT] = refresh_s && !halt_q;
    status_w[mcs_pkg::ST_INIT_BIT] = gathered_s;
    status_w[mcs_pkg::ST_RUN_BIT] = run_s;
    status_w[mcs_pkg::ST_SETUP_BIT] = setup_s;
    status_w[mcs_pkg::ST_WDONE_BIT] = wdone_q;
    status_w[mcs_pkg::ST_STOPPED_BIT] = halt_q;
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [2:0] irq_st_q, irq_mask_q, irq_ev;
  logic init_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_prev_q <= 1'b0;
    end else begin
      init_prev_q <= gathered_s;
    end
  end
  always_comb begin
    irq_ev = 3'h0;
    irq_ev[mcs_pkg::IRQ_WDONE_BIT] = (eep_q == EEP_WRITE) && ack_s && (copy_idx_q == 6'h3f);
    irq_ev[mcs_pkg::IRQ_REFUSED_BIT] = refused_ev;
    irq_ev[mcs_pkg::IRQ_INIT_BIT] = gathered_s && !init_prev_q;
  end
  // set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= mcs_pkg::IRQ_RESET;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_acc && is_is) ? pwdata[2:0] : 3'h0)) | irq_ev;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= mcs_pkg::IRQ_RESET;
    end else if (wr_acc && is_im) begin
      irq_mask_q <= pwdata[2:0];
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // info reads use the memory's own output register, which is filled at the setup edge
  logic rd_info_q;
  logic [31:0] prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      rd_info_q <= 1'b0;
    end else begin
      rd_info_q <= rd_setup && is_info;
      if (rd_setup) begin
        prdata_q <= 32'h0000_0000;
        if (is_sw) begin
          prdata_q <= {24'h00_0000, switch_q};
        end else if (is_cmd) begin
          prdata_q <= {16'h0000, cmd_q};
        end else if (is_st) begin
          prdata_q <= {16'h0000, status_w};
        end else if (is_is) begin
          prdata_q <= {29'h0000_0000, irq_st_q};
        end else if (is_im) begin
          prdata_q <= {29'h0000_0000, irq_mask_q};
        end
      end
    end
  end
  assign prdata = rd_info_q ? {16'h0000, mem_rd} : prdata_q;
endmodule : master_command_status_regs
`default_nettype wire

// ==== rtl/mcs_info_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
// station information words; read data registered
module mcs_info_mem (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:63];
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : mcs_info_mem
`default_nettype wire

// ==== rtl/mcs_pkg.sv ====
// Overview of operation
// - switch positions 1-8 in bits 0-7
// - write-request rising edge copies station info
// - eeprom write only in setup mode
// - completion bit set, cleared after request drops
// - stop bit rise halts, fall resumes link
// - stopped status held while link halted
// - link-active status while image refreshing and link not halted
// - acquisition-done status after station gathering
// - run status mirrors run lamp
// - setup-mode status while setup selected
// - master provides station info after power-up; here the info memory is not loaded at reset, only written over the bus
package mcs_pkg;
  // ----------------------------------------
  // register map (printed offsets are indices)
  // ----------------------------------------
  localparam logic [7:0] SWITCH_IDX = 8'h1a;
  localparam logic [7:0] COMMAND_IDX = 8'h1b;
  localparam logic [7:0] STATUS_IDX = 8'h1c;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h1d;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h1e;
  localparam logic [7:0] INFO_BASE_IDX = 8'h20;
  localparam logic [7:0] INFO_LAST_IDX = 8'h5f;
  localparam int INFO_WORDS = 64;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CMD_EEP_WR_BIT = 4;
  localparam int CMD_STOP_BIT = 5;
  localparam int ST_LINK_BIT = 0;
  localparam int ST_INIT_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_SETUP_BIT = 3;
  localparam int ST_WDONE_BIT = 4;
  localparam int ST_STOPPED_BIT = 5;
  localparam int IRQ_WDONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_INIT_BIT = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  // edges the switch pins need to clear the synchroniser
  localparam int SWITCH_SETTLE = 2;
endpackage : mcs_pkg

// ==== rtl/mcs_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : mcs_sync
`default_nettype wire

// ==== test/master_command_status_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module master_command_status_regs_test;
  typedef struct packed {logic [3:0] pins; logic [31:0] exp;} row_s;
  localparam row_s ROWS [5] = '{'{4'h1, 32'h0000_0001}, '{4'h2, 32'h0000_0002}, '{4'h4, 32'h0000_0004},
    '{4'h8, 32'h0000_0008}, '{4'hf, 32'h0000_000f}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic pready, pslverr, err, setup_mode = 1'b0, run_lamp = 1'b0, link_refreshing = 1'b0;
  logic stations_gathered = 1'b0, link_halt, eep_wr_busy, eep_wr_strobe, eep_wr_ack, irq;
  logic [7:0] dip_switch = 8'h5a;
  logic [5:0] eep_wr_addr;
  logic [15:0] eep_wr_data;
  logic [3:0] delay = 4'h0;
  int fails = 0, n_compared = 0, cycles = 0;
  always #4 pclk = ~pclk;
  master_command_status_regs i_master_command_status_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dip_switch(dip_switch), .setup_mode(setup_mode), .run_lamp(run_lamp),
    .link_refreshing(link_refreshing), .stations_gathered(stations_gathered), .link_halt(link_halt),
    .eep_wr_busy(eep_wr_busy), .eep_wr_addr(eep_wr_addr), .eep_wr_data(eep_wr_data),
    .eep_wr_strobe(eep_wr_strobe), .eep_wr_ack(eep_wr_ack), .irq(irq));
  mcs_eep_model i_mcs_eep_model (.pclk(pclk), .delay(delay), .eep_wr_addr(eep_wr_addr),
    .eep_wr_data(eep_wr_data), .eep_wr_strobe(eep_wr_strobe), .eep_wr_ack(eep_wr_ack));
  // ----
  // bus and compare helpers
  // ----
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask : rd_chk
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      stop_test;
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (ROWS[i]) begin
      {setup_mode, run_lamp, stations_gathered, link_refreshing} <= ROWS[i].pins;
      repeat (5) @(posedge pclk);
      rd_chk(12'h070, ROWS[i].exp);
    end
    rd_chk(12'h068, 32'h0000_005a);
    rd_chk(12'h06c, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 12'h070, 32'h0000_0030);
    rd_chk(12'h070, 32'h0000_000f);
    apb(1'b1, 12'h06c, 32'h0000_0020);
    repeat (3) @(posedge pclk);
    chk({31'h0, link_halt}, 32'h0000_0001);
    rd_chk(12'h070, 32'h0000_002e);
    apb(1'b1, 12'h06c, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    rd_chk(12'h070, 32'h0000_000f);
    setup_mode <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b1, 12'h074, 32'h0000_0007);
    apb(1'b1, 12'h06c, 32'h0000_0010);
    repeat (20) @(posedge pclk);
    rd_chk(12'h070, 32'h0000_0007);
    rd_chk(12'h074, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, 12'h078, 32'h0000_0002);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, 12'h06c, 32'h0000_0000);
    apb(1'b1, 12'h074, 32'h0000_0002);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    {setup_mode, run_lamp, stations_gathered, link_refreshing} <= 4'h8;
    for (int k = 0; k < 2; k++) begin
      delay <= k ? 4'h5 : 4'h0;
      for (int i = 0; i < 64; i++) apb(1'b1, 12'h080 + 12'(4 * i), {16'h0, 8'(i), 8'(k)});
      apb(1'b1, 12'h06c, 32'h0000_0010);
      rdata = 32'h0000_0000;
      for (int n = 0; n < 2000 && rdata[4] !== 1'b1; n++) apb(1'b0, 12'h070, 32'h0000_0000);
      chk(rdata, 32'h0000_0018);
      for (int i = 0; i < 64; i++) chk({16'h0, i_mcs_eep_model.mem[i]}, {16'h0, 8'(i), 8'(k)});
      apb(1'b1, 12'h06c, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      rd_chk(12'h070, 32'h0000_0008);
    end
    stop_test;
  end
endmodule : master_command_status_regs_test
`default_nettype wire

// ==== test/mcs_checker_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic setup_mode,
  input wire logic link_halt,
  input wire logic eep_wr_busy,
  input wire logic eep_wr_strobe,
  input wire logic eep_wr_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cmd_wr = psel && penable && pwrite && paddr == 12'h06c;
  a_ready_tied: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr == 12'h004 |-> pslverr) else $error("no slave error");
  a_halt_rise: assert property (cmd_wr && pwdata[5] && !link_halt |-> ##[1:2] link_halt) else $error("no halt");
  a_halt_fall: assert property (cmd_wr && !pwdata[5] && link_halt |-> ##[1:2] !link_halt) else $error("no resume");
  a_halt_cause: assert property ($rose(link_halt) |-> ($past(cmd_wr) && $past(pwdata[5]))
    || ($past(cmd_wr, 2) && $past(pwdata[5], 2))) else $error("halt without request");
  a_strobe_busy: assert property (eep_wr_strobe |-> eep_wr_busy) else $error("strobe while idle");
  a_strobe_hold: assert property ($fell(eep_wr_strobe) |-> $past(eep_wr_ack, 2) || $past(eep_wr_ack, 3)
    || $past(eep_wr_ack, 4)) else $error("strobe dropped early");
  a_copy_setup: assert property ($rose(eep_wr_busy) |-> $past(setup_mode, 3))
    else $error("copy outside setup");
endmodule : mcs_checker
bind master_command_status_regs mcs_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .setup_mode(setup_mode), .link_halt(link_halt), .eep_wr_busy(eep_wr_busy),
  .eep_wr_strobe(eep_wr_strobe), .eep_wr_ack(eep_wr_ack));
`default_nettype wire

// ==== test/mcs_eep_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// eeprom stand-in: one ack pulse per strobe
// ----
module mcs_eep_model (
  input wire logic pclk,
  input wire logic [3:0] delay,
  input wire logic [5:0] eep_wr_addr,
  input wire logic [15:0] eep_wr_data,
  input wire logic eep_wr_strobe,
  output logic eep_wr_ack
);
  logic [15:0] mem [64];
  logic [3:0] cnt_q;
  logic took_q;
  // ack is a pulse: a held level would be taken again for the next word
  always_ff @(posedge pclk) begin
    eep_wr_ack <= 1'b0;
    if (!eep_wr_strobe) begin
      cnt_q <= 4'h0;
      took_q <= 1'b0;
    end else if (!took_q) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == delay) begin
        eep_wr_ack <= 1'b1;
        took_q <= 1'b1;
        mem[eep_wr_addr] <= eep_wr_data;
      end
    end
  end
endmodule : mcs_eep_model
`default_nettype wire
